// ### wd_refresh_fault_monitor.sv
`timescale 1ns/1ns
module wd_refresh_fault_monitor #(
  parameter int HALF_MS_CYCLES = wd_pkg::HALF_MS_CYCLES,
  parameter int RESET_PULSE_CYCLES = wd_pkg::RESET_PULSE_CYCLES
) (
  input wire logic clk, // system clock, 250 MHz
  input wire logic reset, // async reset, high (power-on)
  input wire logic answer_valid, // one-cycle watchdog answer strobe
  input wire logic answer_good, // answer content correct
  input wire logic cfg_write, // one-cycle configuration write
  input wire wd_pkg::cfg_t cfg_in, // configuration word
  input wire logic recovery_feature_enable, // fault recovery enabled
  input wire logic fault_input_feature_enable, // fault monitor enabled
  input wire logic fault_in_a, // first fault pin
  input wire logic fault_in_b, // second fault pin
  output logic safe_state_out, // safe state asserted, high
  output logic system_reset_out, // reset pulse, high
  output logic safety_init_phase, // in initialisation phase
  output logic [2:0] refresh_count_value, // refresh counter
  output logic [3:0] error_count_value, // watchdog error counter
  output logic recovery_active, // open recovery window running
  output wd_pkg::cfg_t active_cfg // configuration in force
);

  // ************************************************************
  // state
  // ************************************************************
  wd_pkg::mon_t st;
  wd_pkg::mon_t next;
  wd_pkg::pin_pair_t pins;
  wd_pkg::pin_pair_t synced;

  logic half_tick;
  logic timing_on;
  logic win_end;
  logic closed;
  logic running;
  logic good_refresh;
  logic bad_refresh;
  logic fault_a;
  logic fault_b;
  logic fault_pair;
  logic fault_any;
  logic fault_reset;
  logic monitor_on;
  logic recov_ok;
  logic at_limit;
  logic [10:0] win_ms;
  logic [11:0] win_full;
  logic [4:0] err_sum;

  assign pins = '{b: fault_in_b, a: fault_in_a};

  fault_sync u_sync (
    .clk(clk),
    .reset(reset),
    .pins(pins),
    .synced(synced)
  );

  // ************************************************************
  // fault evaluation
  // ************************************************************
  always_comb begin
    fault_a = (synced.a == st.cfg.input_a_polarity);
    fault_b = (synced.b == st.cfg.input_b_polarity);
    if (st.cfg.pair_polarity) begin
      fault_pair = synced.a | ~synced.b;
    end else begin
      fault_pair = ~synced.a | synced.b;
    end
    unique case (st.cfg.fault_input_config)
      wd_pkg::FAULT_OFF: begin
        fault_any = 1'b0;
        fault_reset = 1'b0;
      end
      wd_pkg::FAULT_PAIR: begin
        fault_any = fault_pair;
        fault_reset = fault_pair & st.cfg.pair_reaction;
      end
      wd_pkg::FAULT_EITHER: begin
        fault_any = fault_a | fault_b;
        fault_reset = (fault_a & st.cfg.input_a_reaction) |
                      (fault_b & st.cfg.input_b_reaction);
      end
      wd_pkg::FAULT_A_ONLY: begin
        fault_any = fault_a;
        fault_reset = fault_a & st.cfg.input_a_reaction;
      end
    endcase
  end

  // monitoring waits until the first good refresh has closed init
  assign monitor_on = fault_input_feature_enable &
                      (st.phase == wd_pkg::PH_NORMAL);
  assign recov_ok = recovery_feature_enable &
                    (st.cfg.recovery_window_sel != 4'h0);

  // ************************************************************
  // window timing
  // ************************************************************
  // half-ms ticks so the closed half of a 1 ms window is exact
  assign half_tick = (st.tick_cnt == wd_pkg::TICK_W'(HALF_MS_CYCLES - 1));

  always_comb begin
    if (st.phase == wd_pkg::PH_RECOVERY) begin
      win_ms = wd_pkg::window_ms(st.cfg.recovery_window_sel);
    end else begin
      win_ms = wd_pkg::window_ms(st.cfg.normal_window_sel);
    end
    win_full = {win_ms, 1'b0};
    running = (st.phase == wd_pkg::PH_NORMAL) |
              (st.phase == wd_pkg::PH_RECOVERY);
    timing_on = running & (win_ms != 11'h000);
    win_end = timing_on & half_tick & (st.win_cnt == win_full - 12'h001);
    // recovery window is fully open: no closed part
    closed = (st.phase == wd_pkg::PH_NORMAL) & timing_on &
             (st.win_cnt < {1'b0, win_ms});
    good_refresh = running & answer_valid & answer_good & ~closed;
    bad_refresh = running & ((answer_valid & ~good_refresh) |
                  (win_end & ~answer_valid));
    at_limit = running &
      (st.err_cnt == wd_pkg::error_limit(st.cfg.error_limit_sel));
    err_sum = {1'b0, st.err_cnt} + {1'b0, wd_pkg::ERR_STEP_UP};
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next = st;
    // window restarts after any answer or at its end
    if (answer_valid | win_end | ~timing_on) begin
      next.tick_cnt = '0;
      next.win_cnt = 12'h000;
    end else if (half_tick) begin
      next.tick_cnt = '0;
      next.win_cnt = st.win_cnt + 12'h001;
    end else begin
      next.tick_cnt = st.tick_cnt + wd_pkg::TICK_W'(1);
    end

    if (bad_refresh) begin
      next.refresh_cnt = 3'h0;
      if (err_sum > wd_pkg::ERR_CEIL) begin
        next.err_cnt = wd_pkg::ERR_CEIL[3:0];
      end else begin
        next.err_cnt = err_sum[3:0];
      end
    end else if (good_refresh) begin
      if (st.refresh_cnt ==
          wd_pkg::refresh_max(st.cfg.refresh_limit_sel)) begin
        next.refresh_cnt = 3'h0;
        if (st.err_cnt != 4'h0) begin
          next.err_cnt = st.err_cnt - 4'h1;
        end
      end else begin
        next.refresh_cnt = st.refresh_cnt + 3'h1;
      end
    end

    unique case (st.phase)
      wd_pkg::PH_INIT: begin
        if (cfg_write) begin
          next.cfg = cfg_in;
        end
        if (answer_valid & answer_good) begin
          next.phase = wd_pkg::PH_NORMAL;
        end
      end
      wd_pkg::PH_NORMAL: begin
        if (at_limit & (st.cfg.wdog_error_reaction != 2'h0)) begin
          next.safe = 1'b1;
        end
        if (monitor_on & fault_any) begin
          next.safe = 1'b1;
        end
        if (at_limit & st.cfg.wdog_error_reaction[1]) begin
          next.phase = wd_pkg::PH_RESET;
        end else if (monitor_on & fault_any & recov_ok) begin
          next.phase = wd_pkg::PH_RECOVERY;
          next.tick_cnt = '0;
          next.win_cnt = 12'h000;
        end else if (monitor_on & fault_reset) begin
          next.phase = wd_pkg::PH_RESET;
        end
      end
      wd_pkg::PH_RECOVERY: begin
        if (at_limit & st.cfg.wdog_error_reaction[1]) begin
          next.safe = 1'b1;
          next.phase = wd_pkg::PH_RESET;
        end else if (good_refresh & ~fault_any) begin
          next.phase = wd_pkg::PH_NORMAL;
        end else if (win_end & ~good_refresh) begin
          next.phase = wd_pkg::PH_RESET;
        end
      end
      wd_pkg::PH_RESET: begin
        next.pulse_cnt = st.pulse_cnt - wd_pkg::PULSE_W'(1);
        if (st.pulse_cnt == wd_pkg::PULSE_W'(0)) begin
          next.phase = wd_pkg::PH_INIT;
          next.rst_out = 1'b0;
        end
      end
    endcase

    if ((next.phase == wd_pkg::PH_RESET) &
        (st.phase != wd_pkg::PH_RESET)) begin
      next.rst_out = 1'b1;
      // the entry cycle counts, so the pulse is exactly that long
      next.pulse_cnt = wd_pkg::PULSE_W'(RESET_PULSE_CYCLES - 1);
      next.err_cnt = 4'h0;
      next.refresh_cnt = 3'h0;
    end
    next.init_flag = (next.phase == wd_pkg::PH_INIT);
    next.rec_flag = (next.phase == wd_pkg::PH_RECOVERY);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '{phase: wd_pkg::PH_INIT, cfg: wd_pkg::CFG_RESET,
              init_flag: 1'b1, default: '0};
    end else begin
      st <= next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign safe_state_out = st.safe;
  assign system_reset_out = st.rst_out;
  assign safety_init_phase = st.init_flag;
  assign refresh_count_value = st.refresh_cnt;
  assign error_count_value = st.err_cnt;
  assign recovery_active = st.rec_flag;
  assign active_cfg = st.cfg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_bad_kept;
    bad_refresh && next.phase != wd_pkg::PH_RESET;
  endsequence

  sequence s_rec_expire;
    st.phase == wd_pkg::PH_RECOVERY && win_end && !good_refresh &&
    !at_limit;
  endsequence

  a_cfg_locked: assert property (
    cfg_write && !safety_init_phase |=> $stable(active_cfg)
  ) else $error("configuration changed outside init phase");

  a_refresh_clear: assert property (
    s_bad_kept |=> refresh_count_value == 3'h0
  ) else $error("bad refresh did not clear refresh counter");

  a_refresh_step: assert property (
    good_refresh && next.phase != wd_pkg::PH_RESET &&
    refresh_count_value != wd_pkg::refresh_max(st.cfg.refresh_limit_sel)
    |=> refresh_count_value == $past(refresh_count_value) + 3'h1
  ) else $error("good refresh did not step refresh counter");

  a_error_down: assert property (
    good_refresh && next.phase != wd_pkg::PH_RESET &&
    error_count_value != 4'h0 &&
    refresh_count_value == wd_pkg::refresh_max(st.cfg.refresh_limit_sel)
    |=> error_count_value == $past(error_count_value) - 4'h1
  ) else $error("error counter not lowered at refresh maximum");

  a_error_up: assert property (
    s_bad_kept ##0 error_count_value < 4'hd
    |=> error_count_value == $past(error_count_value) + 4'h2
  ) else $error("watchdog failure did not add two");

  a_limit_safe: assert property (
    at_limit && st.cfg.wdog_error_reaction != 2'h0
    |=> safe_state_out ##1 safe_state_out
  ) else $error("error limit did not assert safe state");

  a_limit_reset: assert property (
    at_limit && st.cfg.wdog_error_reaction[1] |=> system_reset_out [*2]
  ) else $error("error limit did not pulse reset");

  a_fault_safe: assert property (
    monitor_on && fault_any |=> safe_state_out
  ) else $error("fault input did not assert safe state");

  a_fault_reset: assert property (
    monitor_on && fault_reset && !recov_ok |=> system_reset_out
  ) else $error("fault input reaction did not pulse reset");

  a_recovery_enter: assert property (
    monitor_on && fault_any && recov_ok && !at_limit
    |=> recovery_active && safe_state_out && !system_reset_out
  ) else $error("fault did not enter recovery window");

  a_recovery_exit: assert property (
    st.phase == wd_pkg::PH_RECOVERY && good_refresh && !fault_any &&
    !at_limit |=> !recovery_active && !safety_init_phase
  ) else $error("recovery did not return to normal window");

  a_recovery_expire: assert property (
    s_rec_expire |=> system_reset_out [*2] ##[1:300] safety_init_phase
  ) else $error("recovery expiry did not reset and reinit");

  a_pulse_to_init: assert property (
    $fell(system_reset_out) |-> safety_init_phase
  ) else $error("reset pulse end did not return to init");

  a_init_close: assert property (
    safety_init_phase && answer_valid && answer_good |=> !safety_init_phase
  ) else $error("good refresh did not close init phase");

  a_refresh_bound: assert property (
    refresh_count_value <= wd_pkg::refresh_max(st.cfg.refresh_limit_sel)
  ) else $error("refresh counter above its maximum");

endmodule : wd_refresh_fault_monitor

// ### wd_pkg.sv
package wd_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int HALF_MS_NS = 500000;
  // least time, rounded up to whole cycles
  localparam int HALF_MS_CYCLES =
    (HALF_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYCLES = 16;
  localparam int TICK_W = 20;
  localparam int PULSE_W = 8;

  // ************************************************************
  // counter constants
  // ************************************************************
  localparam logic [3:0] ERR_STEP_UP = 4'h2;
  localparam logic [4:0] ERR_CEIL = 5'h0f;

  // ************************************************************
  // configuration reset values (power-on)
  // ************************************************************
  localparam logic [1:0] REFRESH_LIMIT_RST = 2'h0;
  localparam logic [1:0] ERROR_LIMIT_RST = 2'h1;
  localparam logic [1:0] WDOG_REACTION_RST = 2'h0;
  localparam logic [3:0] RECOVERY_WINDOW_RST = 4'hb;
  localparam logic [3:0] NORMAL_WINDOW_RST = 4'h3;
  localparam logic [1:0] FAULT_CONFIG_RST = 2'h1;
  localparam logic PAIR_POLARITY_RST = 1'b0;
  localparam logic PAIR_REACTION_RST = 1'b1;
  localparam logic INPUT_POLARITY_RST = 1'b0;
  localparam logic INPUT_REACTION_RST = 1'b1;

  // fault input configuration codes
  localparam logic [1:0] FAULT_OFF = 2'h0;
  localparam logic [1:0] FAULT_PAIR = 2'h1;
  localparam logic [1:0] FAULT_EITHER = 2'h2;
  localparam logic [1:0] FAULT_A_ONLY = 2'h3;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    PH_INIT = 2'b00,
    PH_NORMAL = 2'b01,
    PH_RECOVERY = 2'b11,
    PH_RESET = 2'b10
  } phase_t;

  typedef struct packed {
    logic [1:0] refresh_limit_sel;
    logic [1:0] error_limit_sel;
    logic [1:0] wdog_error_reaction;
    logic [3:0] recovery_window_sel;
    logic [3:0] normal_window_sel;
    logic [1:0] fault_input_config;
    logic pair_polarity;
    logic pair_reaction;
    logic input_a_polarity;
    logic input_b_polarity;
    logic input_a_reaction;
    logic input_b_reaction;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{
    refresh_limit_sel: REFRESH_LIMIT_RST,
    error_limit_sel: ERROR_LIMIT_RST,
    wdog_error_reaction: WDOG_REACTION_RST,
    recovery_window_sel: RECOVERY_WINDOW_RST,
    normal_window_sel: NORMAL_WINDOW_RST,
    fault_input_config: FAULT_CONFIG_RST,
    pair_polarity: PAIR_POLARITY_RST,
    pair_reaction: PAIR_REACTION_RST,
    input_a_polarity: INPUT_POLARITY_RST,
    input_b_polarity: INPUT_POLARITY_RST,
    input_a_reaction: INPUT_REACTION_RST,
    input_b_reaction: INPUT_REACTION_RST
  };

  typedef struct packed {
    logic b;
    logic a;
  } pin_pair_t;

  typedef struct packed {
    pin_pair_t meta;
    pin_pair_t held;
  } sync_t;

  typedef struct packed {
    phase_t phase;
    cfg_t cfg;
    logic [TICK_W-1:0] tick_cnt;
    logic [11:0] win_cnt;
    logic [2:0] refresh_cnt;
    logic [3:0] err_cnt;
    logic [PULSE_W-1:0] pulse_cnt;
    logic safe;
    logic rst_out;
    logic init_flag;
    logic rec_flag;
  } mon_t;

  // ************************************************************
  // lookup functions
  // ************************************************************
  function automatic logic [2:0] refresh_max(input logic [1:0] sel);
    unique case (sel)
      2'h0: refresh_max = 3'h6;
      2'h1: refresh_max = 3'h4;
      2'h2: refresh_max = 3'h2;
      2'h3: refresh_max = 3'h1;
    endcase
  endfunction : refresh_max

  function automatic logic [3:0] error_limit(input logic [1:0] sel);
    unique case (sel)
      2'h0: error_limit = 4'h8;
      2'h1: error_limit = 4'h6;
      2'h2: error_limit = 4'h4;
      2'h3: error_limit = 4'h2;
    endcase
  endfunction : error_limit

  // window length in ms; code 0 means disabled
  function automatic logic [10:0] window_ms(input logic [3:0] sel);
    unique case (sel)
      4'h0: window_ms = 11'h000;
      4'h1: window_ms = 11'h001;
      4'h2: window_ms = 11'h002;
      4'h3: window_ms = 11'h003;
      4'h4: window_ms = 11'h004;
      4'h5: window_ms = 11'h006;
      4'h6: window_ms = 11'h008;
      4'h7: window_ms = 11'h00c;
      4'h8: window_ms = 11'h010;
      4'h9: window_ms = 11'h018;
      4'ha: window_ms = 11'h020;
      4'hb: window_ms = 11'h040;
      4'hc: window_ms = 11'h080;
      4'hd: window_ms = 11'h100;
      4'he: window_ms = 11'h200;
      4'hf: window_ms = 11'h400;
    endcase
  endfunction : window_ms

endpackage : wd_pkg

// ### fault_sync.sv
`timescale 1ns/1ns
module fault_sync (
  input wire logic clk, // system clock
  input wire logic reset, // async reset, high
  input wire wd_pkg::pin_pair_t pins, // raw fault pins
  output wd_pkg::pin_pair_t synced // resynchronised pins
);

  wd_pkg::sync_t st;
  wd_pkg::sync_t next_st;
  logic [1:0] primed;

  // the first stage feeds only the second stage
  always_comb begin
    next_st = st;
    next_st.meta = pins;
    next_st.held = st.meta;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign synced = st.held;

  // ************************************************************
  // checks
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      primed <= 2'h0;
    end else if (primed != 2'h3) begin
      primed <= primed + 2'h1;
    end
  end

  a_sync_two_stage: assert property (
    @(posedge clk) disable iff (reset)
    (primed == 2'h3) |-> (synced == $past(pins, 2))
  ) else $error("fault pins not delayed by two stages");

endmodule : fault_sync

// ### host_model.sv
`timescale 1ns/1ns
// ****
// host side of the watchdog and fault pins
// ****
module host_model (
  input wire logic clk, // system clock
  input wire logic send, // bench asks for one answer
  input wire logic good, // content of that answer
  input wire wd_pkg::pin_pair_t fault_req, // wanted pin levels
  output logic answer_valid, // answer strobe
  output logic answer_good, // answer content
  output logic fault_in_a, // first fault pin
  output logic fault_in_b // second fault pin
);
  initial begin
    answer_valid = 1'b0;
    answer_good = 1'b0;
    fault_in_a = 1'b1;
    fault_in_b = 1'b0;
  end
  // the bench spaces answers; one lands in a closed part, and one recovery window and one normal window are left to end unanswered
  always @(posedge clk) begin
    answer_valid <= send;
    // content is not held between answers, so it flips
    answer_good <= send ? good : !answer_good;
    fault_in_a <= fault_req.a;
    fault_in_b <= fault_req.b;
  end
endmodule : host_model

// ### test_wd_refresh_fault_monitor.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  num_errors++; $display("[FAIL] %0t got %0h want %0h", $time, got, exp); \
  end end
module test_wd_refresh_fault_monitor;
  localparam int HALF = 4;
  localparam int RPC = 8;
  localparam int LIMIT = 30000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic send = 1'b0;
  logic good = 1'b0;
  logic cfg_write = 1'b0;
  logic rec_en = 1'b0;
  logic flt_en = 1'b0;
  wd_pkg::cfg_t cfg_in = wd_pkg::CFG_RESET;
  wd_pkg::pin_pair_t pins = 2'h1;
  logic answer_valid, answer_good, fault_in_a, fault_in_b;
  logic safe_state_out, system_reset_out, safety_init_phase;
  logic recovery_active, gg;
  logic [2:0] refresh_count_value, r;
  logic [3:0] error_count_value, e;
  logic [1:0] x;
  logic [2:0] mx [4] = '{3'h6, 3'h4, 3'h2, 3'h1};
  wd_pkg::cfg_t active_cfg, base, c;
  int num_errors = 0;
  int n_compared = 0;
  int seed = 93;
  int cycles = 0;
  int n, t;

  host_model i_host_model (.clk(clk), .send(send), .good(good),
    .fault_req(pins), .answer_valid(answer_valid),
    .answer_good(answer_good), .fault_in_a(fault_in_a),
    .fault_in_b(fault_in_b));
  wd_refresh_fault_monitor #(.HALF_MS_CYCLES(HALF),
    .RESET_PULSE_CYCLES(RPC)) i_wd_refresh_fault_monitor (.clk(clk),
    .reset(reset), .answer_valid(answer_valid), .answer_good(answer_good),
    .cfg_write(cfg_write), .cfg_in(cfg_in),
    .recovery_feature_enable(rec_en), .fault_input_feature_enable(flt_en),
    .fault_in_a(fault_in_a), .fault_in_b(fault_in_b),
    .safe_state_out(safe_state_out), .system_reset_out(system_reset_out),
    .safety_init_phase(safety_init_phase),
    .refresh_count_value(refresh_count_value),
    .error_count_value(error_count_value),
    .recovery_active(recovery_active), .active_cfg(active_cfg));

  initial begin
    forever #2 clk = ~clk;
  end
  // a hung wait ends the run as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      summarize();
    end
  end

  // ****
  // helpers
  // ****
  task automatic summarize();
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic boot(input wd_pkg::cfg_t v);
    @(posedge clk) reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    `CHK(active_cfg, wd_pkg::CFG_RESET)
    @(posedge clk);
    cfg_write <= 1'b1;
    cfg_in <= v;
    @(posedge clk) cfg_write <= 1'b0;
    @(negedge clk);
    `CHK(active_cfg, v)
  endtask : boot

  // answer is taken on the third edge; counters read after it
  task automatic answer(input logic g);
    @(posedge clk);
    send <= 1'b1;
    good <= g;
    @(posedge clk) send <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : answer

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  task automatic pulse(output int k);
    k = 0;
    repeat (40) begin
      @(negedge clk);
      if (system_reset_out === 1'b1) k++;
    end
  endtask : pulse

  // {fault seen, reset wanted}
  function automatic logic [1:0] flt(input wd_pkg::cfg_t v,
                                     input wd_pkg::pin_pair_t p);
    logic fa, fb;
    fa = p.a == v.input_a_polarity;
    fb = p.b == v.input_b_polarity;
    case (v.fault_input_config)
      2'h1: flt = {v.pair_polarity ? p.a | !p.b : !p.a | p.b,
                   v.pair_reaction};
      2'h2: flt = {fa | fb, fa & v.input_a_reaction | fb & v.input_b_reaction};
      2'h3: flt = {fa, v.input_a_reaction};
      default: flt = 2'h0;
    endcase
    flt[0] = flt[0] & flt[1];
  endfunction : flt

  // ****
  // scenarios
  // ****
  initial begin
    base = wd_pkg::CFG_RESET;
    base.normal_window_sel = 4'h0;
    base.fault_input_config = 2'h0;
    for (int s = 0; s < 4; s++) begin
      c = base;
      c.refresh_limit_sel = 2'(s);
      c.error_limit_sel = 2'h0;
      boot(c);
      answer(1'b1);
      `CHK(safety_init_phase, 1'b0)
      answer(1'b0);
      r = 3'h0;
      e = 4'h2;
      repeat (30) begin
        gg = ($random(seed) & 3) != 0;
        answer(gg);
        if (!gg) begin
          r = 3'h0;
          e = (e > 4'hd) ? 4'hf : e + 4'h2;
        end else if (r == mx[s]) begin
          r = 3'h0;
          e = (e == 4'h0) ? e : e - 4'h1;
        end else r = r + 3'h1;
        `CHK(refresh_count_value, r)
        `CHK(error_count_value, e)
        `CHK(safe_state_out, 1'b0)
      end
      // writes outside the init phase must be dropped
      @(posedge clk);
      cfg_write <= 1'b1;
      cfg_in <= ~c;
      @(posedge clk) cfg_write <= 1'b0;
      @(negedge clk);
      `CHK(active_cfg, c)
    end
    for (int s = 0; s < 4; s++) begin
      c = base;
      c.error_limit_sel = 2'h3;
      c.wdog_error_reaction = 2'(s);
      boot(c);
      answer(1'b1);
      answer(1'b0);
      pulse(n);
      `CHK(safe_state_out, s != 0)
      `CHK(n, s > 1 ? RPC : 0)
      `CHK(safety_init_phase, s > 1)
    end
    for (int k = 0; k < 24; k++) begin
      c = base;
      {c.pair_polarity, c.pair_reaction, c.input_a_polarity,
       c.input_b_polarity, c.input_a_reaction,
       c.input_b_reaction} = 6'($random(seed));
      c.fault_input_config = 2'(k);
      @(posedge clk) flt_en <= (k % 8) < 6;
      pins <= 2'($random(seed));
      boot(c);
      cyc(8);
      `CHK(safe_state_out, 1'b0)
      @(posedge clk) pins <= 2'($random(seed));
      cyc(4);
      answer(1'b1);
      pulse(n);
      x = flt_en ? flt(c, pins) : 2'h0;
      `CHK(safe_state_out, x[1])
      `CHK(n, x[0] ? RPC : 0)
    end
    c = base;
    c.fault_input_config = 2'h1;
    c.recovery_window_sel = 4'h2;
    @(posedge clk) rec_en <= 1'b1;
    flt_en <= 1'b1;
    pins <= 2'h1;
    boot(c);
    answer(1'b1);
    @(posedge clk) pins <= 2'h0;
    cyc(6);
    `CHK({safe_state_out, recovery_active}, 2'h3)
    repeat (4) begin
      answer(1'b1);
      cyc(4);
      `CHK({recovery_active, system_reset_out}, 2'h2)
    end
    @(posedge clk) pins <= 2'h1;
    cyc(4);
    answer(1'b1);
    cyc(2);
    `CHK(recovery_active, 1'b0)
    @(posedge clk) pins <= 2'h0;
    t = 0;
    while (recovery_active !== 1'b1 && t < 20) begin
      cyc(1);
      t++;
    end
    `CHK(recovery_active, 1'b1)
    t = 0;
    while (system_reset_out !== 1'b1 && t < 40) begin
      cyc(1);
      t++;
    end
    `CHK(t >= 3 * HALF && t <= 4 * HALF + 3, 1'b1)
    pulse(n);
    `CHK(safety_init_phase, 1'b1)
    `CHK(n, RPC - 1)
    c = base;
    c.normal_window_sel = 4'h3;
    @(posedge clk) flt_en <= 1'b0;
    pins <= 2'h1;
    boot(c);
    answer(1'b1);
    answer(1'b1);
    `CHK({refresh_count_value, error_count_value}, 7'h02)
    cyc(14);
    answer(1'b1);
    `CHK({refresh_count_value, error_count_value}, 7'h12)
    cyc(30);
    `CHK({refresh_count_value, error_count_value}, 7'h04)
    summarize();
  end
endmodule : test_wd_refresh_fault_monitor
